// ===== logic/iacu_pkg.sv
// Constants and encodings for the integer arithmetic and compare unit.
// ****************************************************************
// ****************************************************************
package iacu_pkg;
   localparam int unsigned WORD_W = 32;
   localparam int unsigned IMM_W = 8;
   localparam int unsigned OP_W = 7;
   localparam int unsigned VEC_W = 8;
   localparam int unsigned FLAG_W = 4;

   // Operation code fields
   localparam int unsigned OP_CLS_HI = 6;
   localparam int unsigned OP_CLS_LO = 5;
   localparam int unsigned OP_SUB_BIT = 4;
   localparam int unsigned OP_REV_BIT = 3;
   localparam int unsigned OP_CRY_BIT = 2;
   localparam int unsigned OP_CHK_HI = 1;
   localparam int unsigned OP_ASRT_BIT = 4;
   localparam int unsigned OP_UNS_BIT = 3;
   localparam int unsigned OP_REL_HI = 2;
   localparam int unsigned OP_IDX_HI = 4;

   localparam logic [1:0] CLS_ARITH = 2'h0;
   localparam logic [1:0] CLS_CMP = 2'h1;
   localparam logic [1:0] CLS_MULDIV = 2'h2;
   localparam logic [1:0] CLS_EMUL = 2'h3;

   localparam logic [1:0] CHK_NONE = 2'h0;
   localparam logic [1:0] CHK_SIGNED = 2'h1;
   localparam logic [1:0] CHK_UNSIGNED = 2'h2;

   localparam logic [2:0] REL_EQ = 3'h0;
   localparam logic [2:0] REL_NE = 3'h1;
   localparam logic [2:0] REL_LT = 3'h2;
   localparam logic [2:0] REL_LE = 3'h3;
   localparam logic [2:0] REL_GT = 3'h4;
   localparam logic [2:0] REL_GE = 3'h5;
   localparam logic [2:0] REL_BYTE = 3'h6;

   // Multiply and divide operation indices
   localparam logic [4:0] MD_PRODUCT_LOW_UNSIGNED = 5'h00;
   localparam logic [4:0] MD_PRODUCT_LOW_SIGNED = 5'h01;
   localparam logic [4:0] MD_PRODUCT_STEP_SIGNED = 5'h02;
   localparam logic [4:0] MD_PRODUCT_STEP_FINAL = 5'h03;
   localparam logic [4:0] MD_PRODUCT_HIGH_SIGNED = 5'h04;
   localparam logic [4:0] MD_PRODUCT_HIGH_UNSIGNED = 5'h05;
   localparam logic [4:0] MD_PRODUCT_STEP_UNSIGNED = 5'h06;
   localparam logic [4:0] MD_QUOTIENT_FULL_SIGNED = 5'h07;
   localparam logic [4:0] MD_QUOTIENT_FULL_UNSIGNED = 5'h08;
   localparam logic [4:0] MD_QUOTIENT_STEP_INIT = 5'h09;
   localparam logic [4:0] MD_QUOTIENT_STEP = 5'h0A;
   localparam logic [4:0] MD_QUOTIENT_STEP_FINAL = 5'h0B;
   localparam logic [4:0] MD_REMAINDER_FIXUP = 5'h0C;
   localparam logic [4:0] MD_COUNT = 5'h0D;
   localparam logic [4:0] EMUL_COUNT = 5'h10;

   // Trap vectors
   localparam logic [VEC_W-1:0] VEC_ILLEGAL = 8'h00;
   localparam logic [VEC_W-1:0] VEC_PROTECT = 8'h05;
   localparam logic [VEC_W-1:0] VEC_OUT_OF_RANGE = 8'h02;
   localparam logic [VEC_W-1:0] VEC_MD_BASE = 8'h20;
   localparam logic [VEC_W-1:0] VEC_EMUL_BASE = 8'h30;
   localparam logic [VEC_W-1:0] VEC_USER_LIMIT = 8'h3F;

   // Flag positions
   localparam int unsigned FL_C = 0;
   localparam int unsigned FL_Z = 1;
   localparam int unsigned FL_N = 2;
   localparam int unsigned FL_V = 3;
   localparam logic [FLAG_W-1:0] FLAGS_RESET = 4'h0;
   localparam logic [WORD_W-1:0] BOOL_TRUE = 32'h80000000;
   localparam logic [WORD_W-1:0] BOOL_FALSE = 32'h00000000;
endpackage : iacu_pkg

// ===== logic/iacu_unit.sv
// Integer arithmetic and compare/assert execution unit.
`timescale 1ns/1ns
`default_nettype none
module iacu_unit
   import iacu_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_valid,
   input wire logic [OP_W-1:0] i_op,
   input wire logic [WORD_W-1:0] i_src_a,
   input wire logic [WORD_W-1:0] i_src_b,
   input wire logic [IMM_W-1:0] i_imm8,
   input wire logic i_use_imm,
   input wire logic [VEC_W-1:0] i_vector,
   input wire logic i_user_mode,
   output logic o_done,
   output logic o_write,
   output logic [WORD_W-1:0] o_result,
   output logic o_trap,
   output logic [VEC_W-1:0] o_trap_vector,
   output logic [FLAG_W-1:0] o_flags
);
   // ****************************************************************
   // Operand selection and decode
   // ****************************************************************
   logic [WORD_W-1:0] opd_b;
   logic [1:0] op_cls;
   logic is_sub;
   logic is_rev;
   logic use_cry;
   logic [1:0] chk;
   logic [2:0] rel;
   logic is_assert;
   logic is_uns;
   logic [4:0] op_idx;

   assign opd_b = i_use_imm ? {{(WORD_W-IMM_W){1'b0}}, i_imm8} : i_src_b;
   assign op_cls = i_op[OP_CLS_HI:OP_CLS_LO];
   assign is_sub = i_op[OP_SUB_BIT];
   assign is_rev = i_op[OP_REV_BIT];
   assign use_cry = i_op[OP_CRY_BIT];
   assign chk = i_op[OP_CHK_HI:0];
   assign rel = i_op[OP_REL_HI:0];
   assign is_assert = i_op[OP_ASRT_BIT];
   assign is_uns = i_op[OP_UNS_BIT];
   assign op_idx = i_op[OP_IDX_HI:0];

   // ****************************************************************
   // Adder
   // ****************************************************************
   logic [WORD_W-1:0] add_x;
   logic [WORD_W-1:0] add_y;
   logic add_cin;
   logic [WORD_W:0] add_sum;
   logic [WORD_W-1:0] add_res;
   logic add_cout;
   logic add_sovf;

   // Subtract is x + ~y + cin; cin is 1 or the carry for borrow forms
   always_comb begin
      add_x = is_rev ? opd_b : i_src_a;
      add_y = is_rev ? i_src_a : opd_b;
      if (is_sub) begin
         add_y = ~add_y;
      end
      add_cin = use_cry ? o_flags[FL_C] : is_sub;
   end

   assign add_sum = {1'b0, add_x} + {1'b0, add_y} + {{WORD_W{1'b0}}, add_cin};
   assign add_res = add_sum[WORD_W-1:0];
   assign add_cout = add_sum[WORD_W];
   assign add_sovf = (add_x[WORD_W-1] == add_y[WORD_W-1]) && (add_res[WORD_W-1] != add_x[WORD_W-1]);

   // ****************************************************************
   // Comparator
   // ****************************************************************
   logic cmp_eq;
   logic cmp_lt;
   logic cmp_byte;
   logic cmp_true;
   logic cmp_legal;

   assign cmp_eq = i_src_a == opd_b;
   assign cmp_lt = is_uns ? (i_src_a < opd_b) : ($signed(i_src_a) < $signed(opd_b));
   assign cmp_byte = (i_src_a[7:0] == opd_b[7:0]) || (i_src_a[15:8] == opd_b[15:8]) ||
      (i_src_a[23:16] == opd_b[23:16]) || (i_src_a[31:24] == opd_b[31:24]);

   always_comb begin
      cmp_legal = 1'b1;
      case (rel)
         REL_EQ: cmp_true = cmp_eq;
         REL_NE: cmp_true = !cmp_eq;
         REL_LT: cmp_true = cmp_lt;
         REL_LE: cmp_true = cmp_lt || cmp_eq;
         REL_GT: cmp_true = !cmp_lt && !cmp_eq;
         REL_GE: cmp_true = !cmp_lt;
         REL_BYTE: begin
            cmp_true = cmp_byte;
            cmp_legal = !is_assert && !is_uns;
         end
         default: begin
            cmp_true = 1'b0;
            cmp_legal = 1'b0;
         end
      endcase
      if ((rel == REL_EQ || rel == REL_NE) && is_uns) begin
         cmp_legal = 1'b0;
      end
   end

   // ****************************************************************
   // Outcome selection
   // ****************************************************************
   logic next_write;
   logic [WORD_W-1:0] next_result;
   logic next_trap;
   logic [VEC_W-1:0] next_vector;
   logic next_flag_upd;

   always_comb begin
      next_write = 1'b0;
      next_result = o_result;
      next_trap = 1'b0;
      next_vector = o_trap_vector;
      next_flag_upd = 1'b0;
      case (op_cls)
         CLS_ARITH: begin
            if (chk == 2'h3) begin
               next_trap = 1'b1;
               next_vector = VEC_ILLEGAL;
            end else begin
               next_write = 1'b1;
               next_result = add_res;
               next_flag_upd = 1'b1;
               if (chk == CHK_SIGNED && add_sovf) begin
                  next_trap = 1'b1;
                  next_vector = VEC_OUT_OF_RANGE;
               end
               if (chk == CHK_UNSIGNED && (is_sub ? !add_cout : add_cout)) begin
                  next_trap = 1'b1;
                  next_vector = VEC_OUT_OF_RANGE;
               end
            end
         end
         CLS_CMP: begin
            if (!cmp_legal) begin
               next_trap = 1'b1;
               next_vector = VEC_ILLEGAL;
            end else if (is_assert) begin
               if (!cmp_true) begin
                  next_trap = 1'b1;
                  next_vector = (i_user_mode && i_vector <= VEC_USER_LIMIT) ? VEC_PROTECT : i_vector;
               end
            end else begin
               next_write = 1'b1;
               next_result = cmp_true ? BOOL_TRUE : BOOL_FALSE;
            end
         end
         CLS_MULDIV: begin
            next_trap = 1'b1;
            next_vector = (op_idx < MD_COUNT) ? VEC_MD_BASE + {3'h0, op_idx} : VEC_ILLEGAL;
         end
         CLS_EMUL: begin
            next_trap = 1'b1;
            next_vector = (op_idx < EMUL_COUNT) ? VEC_EMUL_BASE + {3'h0, op_idx} : VEC_ILLEGAL;
         end
         default: begin
            next_trap = 1'b1;
            next_vector = VEC_ILLEGAL;
         end
      endcase
   end

   // ****************************************************************
   // Registered results
   // ****************************************************************
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_done <= 1'b0;
         o_write <= 1'b0;
         o_trap <= 1'b0;
      end else begin
         o_done <= i_valid;
         o_write <= i_valid && next_write;
         o_trap <= i_valid && next_trap;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_result <= BOOL_FALSE;
         o_trap_vector <= VEC_ILLEGAL;
      end else if (i_valid) begin
         o_result <= next_result;
         o_trap_vector <= next_vector;
      end
   end

   // Arithmetic status register
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_flags <= FLAGS_RESET;
      end else if (i_valid && next_flag_upd) begin
         o_flags[FL_C] <= add_cout;
         o_flags[FL_Z] <= add_res == BOOL_FALSE;
         o_flags[FL_N] <= add_res[WORD_W-1];
         o_flags[FL_V] <= add_sovf;
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);

   logic arith_ok;
   assign arith_ok = i_valid && op_cls == CLS_ARITH && chk != 2'h3;

   chk_done_one_cycle: assert property (i_valid |=> o_done ##1 (o_done == $past(i_valid)))
      else $error("operation did not finish in one cycle");
   chk_muldiv_traps: assert property (i_valid && op_cls == CLS_MULDIV && op_idx < MD_COUNT
      |=> o_trap && !o_write && o_trap_vector == VEC_MD_BASE + {3'h0, $past(op_idx)})
      else $error("multiply or divide not routed to its trap");
   chk_imm_operand: assert property (arith_ok && i_use_imm && !is_sub && !use_cry
      |=> o_result == $past(i_src_a) + {24'h0, $past(i_imm8)})
      else $error("immediate operand not used");
   chk_illegal_op: assert property (i_valid && op_cls == CLS_ARITH && chk == 2'h3
      |=> o_trap && o_trap_vector == VEC_ILLEGAL && !o_write)
      else $error("illegal code did not trap");
   chk_flags_follow: assert property (arith_ok |=> o_flags[FL_Z] == (o_result == BOOL_FALSE)
      && o_flags[FL_N] == o_result[WORD_W-1])
      else $error("status flags do not match result");
   chk_carry_add: assert property (arith_ok && !is_sub && use_cry
      |=> o_result == $past(i_src_a) + $past(opd_b) + {31'h0, $past(o_flags[FL_C])})
      else $error("carry-in add wrong");
   chk_borrow_sub: assert property (arith_ok && is_sub && !is_rev && use_cry
      |=> o_result == $past(i_src_a) - $past(opd_b) - 32'h1 + {31'h0, $past(o_flags[FL_C])})
      else $error("borrow subtract wrong");
   chk_reverse_sub: assert property (arith_ok && is_sub && is_rev && !use_cry
      |=> o_result == $past(opd_b) - $past(i_src_a))
      else $error("reverse subtract wrong");
   chk_signed_ovf: assert property (arith_ok && chk == CHK_SIGNED
      |=> o_write && (o_trap == o_flags[FL_V]))
      else $error("signed overflow trap mismatch");
   chk_unsigned_add: assert property (arith_ok && chk == CHK_UNSIGNED && !is_sub
      |=> o_trap == o_flags[FL_C])
      else $error("unsigned add trap mismatch");
   chk_unsigned_sub: assert property (arith_ok && chk == CHK_UNSIGNED && is_sub
      |=> o_trap == !o_flags[FL_C])
      else $error("unsigned subtract trap mismatch");
   chk_bool_word: assert property (o_write && $past(op_cls) == CLS_CMP
      |-> o_result == BOOL_TRUE || o_result == BOOL_FALSE)
      else $error("boolean result malformed");
   chk_assert_prot: assert property (i_valid && op_cls == CLS_CMP && is_assert && cmp_legal && !cmp_true
      && i_user_mode && i_vector <= VEC_USER_LIMIT |=> o_trap && o_trap_vector == VEC_PROTECT)
      else $error("user assert not a protection trap");
   chk_assert_pass: assert property (i_valid && op_cls == CLS_CMP && is_assert && cmp_legal && cmp_true
      |=> !o_trap && !o_write)
      else $error("passing assert trapped");

   // ****************************************************************
   // Compare, arithmetic, trap and hold checks
   // ****************************************************************
   logic cmp_op;
   logic [WORD_W-1:0] lane_diff;
   assign cmp_op = i_valid && op_cls == CLS_CMP && !is_assert;
   assign lane_diff = i_src_a ^ opd_b;

   chk_cmp_eq_word: assert property (cmp_op && rel == REL_EQ && !is_uns
      |=> o_result == ($past(i_src_a) == $past(opd_b) ? BOOL_TRUE : BOOL_FALSE))
      else $error("equal compare wrong");
   chk_cmp_ne_word: assert property (cmp_op && rel == REL_NE && !is_uns
      |=> o_result == ($past(i_src_a) != $past(opd_b) ? BOOL_TRUE : BOOL_FALSE))
      else $error("not-equal compare wrong");
   chk_cmp_lt_signed: assert property (cmp_op && rel == REL_LT && !is_uns
      |=> o_result[WORD_W-1] == ($signed($past(i_src_a)) < $signed($past(opd_b))))
      else $error("signed less compare wrong");
   chk_cmp_lt_unsigned: assert property (cmp_op && rel == REL_LT && is_uns
      |=> o_result[WORD_W-1] == ($past(i_src_a) < $past(opd_b)))
      else $error("unsigned less compare wrong");
   chk_cmp_le_signed: assert property (cmp_op && rel == REL_LE && !is_uns
      |=> o_result[WORD_W-1] == ($signed($past(i_src_a)) <= $signed($past(opd_b))))
      else $error("signed less-or-equal compare wrong");
   chk_cmp_le_unsigned: assert property (cmp_op && rel == REL_LE && is_uns
      |=> o_result[WORD_W-1] == ($past(i_src_a) <= $past(opd_b)))
      else $error("unsigned less-or-equal compare wrong");
   chk_cmp_gt_signed: assert property (cmp_op && rel == REL_GT && !is_uns
      |=> o_result[WORD_W-1] == ($signed($past(i_src_a)) > $signed($past(opd_b))))
      else $error("signed greater compare wrong");
   chk_cmp_gt_unsigned: assert property (cmp_op && rel == REL_GT && is_uns
      |=> o_result[WORD_W-1] == ($past(i_src_a) > $past(opd_b)))
      else $error("unsigned greater compare wrong");
   chk_cmp_ge_signed: assert property (cmp_op && rel == REL_GE && !is_uns
      |=> o_result[WORD_W-1] == ($signed($past(i_src_a)) >= $signed($past(opd_b))))
      else $error("signed greater-or-equal compare wrong");
   chk_cmp_ge_unsigned: assert property (cmp_op && rel == REL_GE && is_uns
      |=> o_result[WORD_W-1] == ($past(i_src_a) >= $past(opd_b)))
      else $error("unsigned greater-or-equal compare wrong");
   chk_byte_lanes: assert property (cmp_op && rel == REL_BYTE && !is_uns
      |=> o_result[WORD_W-1] == ($past(lane_diff[7:0]) == 8'h00 || $past(lane_diff[15:8]) == 8'h00
      || $past(lane_diff[23:16]) == 8'h00 || $past(lane_diff[31:24]) == 8'h00))
      else $error("byte match compare wrong");
   chk_cmp_writes: assert property (cmp_op && cmp_legal
      |=> o_write && !o_trap)
      else $error("compare did not write its result");
   chk_cmp_flags_kept: assert property (i_valid && op_cls == CLS_CMP
      |=> $stable(o_flags))
      else $error("compare changed the status flags");
   chk_cmp_bad_rel: assert property (i_valid && op_cls == CLS_CMP && rel > REL_BYTE
      |=> o_trap && !o_write && o_trap_vector == VEC_ILLEGAL)
      else $error("undefined compare did not trap");
   chk_byte_bad_form: assert property (i_valid && op_cls == CLS_CMP && rel == REL_BYTE && (is_assert || is_uns)
      |=> o_trap && !o_write && o_trap_vector == VEC_ILLEGAL)
      else $error("bad byte match form did not trap");
   chk_assert_vector: assert property (i_valid && op_cls == CLS_CMP && is_assert && cmp_legal && !cmp_true && !i_user_mode
      |=> o_trap && !o_write && o_trap_vector == $past(i_vector))
      else $error("failing assert used wrong vector");
   chk_muldiv_bad_idx: assert property (i_valid && op_cls == CLS_MULDIV && op_idx >= MD_COUNT
      |=> o_trap && !o_write && o_trap_vector == VEC_ILLEGAL)
      else $error("unknown multiply or divide code did not trap illegal");
   chk_emul_vector: assert property (i_valid && op_cls == CLS_EMUL && op_idx < EMUL_COUNT
      |=> o_trap && !o_write && o_trap_vector == VEC_EMUL_BASE + {3'h0, $past(op_idx)})
      else $error("reserved code not routed to its trap");
   chk_emul_bad_idx: assert property (i_valid && op_cls == CLS_EMUL && op_idx >= EMUL_COUNT
      |=> o_trap && !o_write && o_trap_vector == VEC_ILLEGAL)
      else $error("unknown reserved code did not trap illegal");
   chk_sub_result: assert property (arith_ok && is_sub && !is_rev && !use_cry
      |=> o_write && o_result == $past(i_src_a) - $past(opd_b))
      else $error("subtract wrong");
   chk_rev_borrow: assert property (arith_ok && is_sub && is_rev && use_cry
      |=> o_result == $past(opd_b) - $past(i_src_a) - 32'h1 + {31'h0, $past(o_flags[FL_C])})
      else $error("reverse borrow subtract wrong");
   chk_carry_flag_add: assert property (arith_ok && !is_sub && !use_cry
      |=> o_flags[FL_C] == (o_result < $past(i_src_a)))
      else $error("add carry flag wrong");
   chk_carry_flag_sub: assert property (arith_ok && is_sub && !is_rev && !use_cry
      |=> o_flags[FL_C] == ($past(i_src_a) >= $past(opd_b)))
      else $error("subtract carry flag wrong");
   chk_unsigned_rsub: assert property (arith_ok && chk == CHK_UNSIGNED && is_sub && is_rev && !use_cry
      |=> o_trap == ($past(opd_b) < $past(i_src_a)))
      else $error("unsigned reverse subtract trap mismatch");
   chk_no_check_quiet: assert property (arith_ok && chk == CHK_NONE
      |=> o_write && !o_trap)
      else $error("unchecked arithmetic trapped");
   chk_range_vector: assert property (o_trap && $past(arith_ok)
      |-> o_trap_vector == VEC_OUT_OF_RANGE)
      else $error("arithmetic trap used wrong vector");
   chk_idle_quiet: assert property (!i_valid
      |=> !o_done && !o_write && !o_trap)
      else $error("output pulse without an operation");
   chk_idle_holds: assert property (!i_valid
      |=> $stable(o_result) && $stable(o_trap_vector) && $stable(o_flags))
      else $error("registered outputs changed without an operation");

   cov_signed_ovf: cover property (arith_ok && chk == CHK_SIGNED ##1 o_trap);
   cov_carry_chain: cover property (arith_ok && !use_cry ##1 arith_ok && use_cry);
   cov_byte_match: cover property (i_valid && op_cls == CLS_CMP && rel == REL_BYTE && cmp_true);
   cov_user_prot: cover property (o_trap && o_trap_vector == VEC_PROTECT);
   cov_muldiv_trap: cover property (i_valid && op_cls == CLS_MULDIV ##1 o_trap);
endmodule : iacu_unit
`default_nettype wire

// ===== verification/iacu_decode_model.sv
// Decode stage and register file stand-in that presents operands to the unit.
`timescale 1ns/1ns
`default_nettype none
module iacu_decode_model
   import iacu_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_req,
   input wire logic [WORD_W-1:0] i_a,
   input wire logic [WORD_W-1:0] i_b,
   output logic o_valid,
   output logic [WORD_W-1:0] o_src_a,
   output logic [WORD_W-1:0] o_src_b
);
   logic [WORD_W-1:0] noise = 32'h0000A5A5;

   // Idle read ports churn instead of holding the last operands
   always @(negedge i_clk) begin
      noise <= {noise[30:0], noise[31] ^ noise[21]};
   end

   assign o_valid = i_req;
   assign o_src_a = i_req ? i_a : noise;
   assign o_src_b = i_req ? i_b : ~noise;
endmodule : iacu_decode_model
`default_nettype wire

// ===== verification/iacu_unit_tb.sv
// Self-checking bench for the integer arithmetic and compare unit.
`timescale 1ns/1ns
`default_nettype none
module iacu_unit_tb
   import iacu_pkg::*;
;
   typedef struct packed {
      logic wr;
      logic [WORD_W-1:0] res;
      logic tr;
      logic [VEC_W-1:0] vec;
      logic [FLAG_W-1:0] fl;
   } iacu_exp_t;
   iacu_exp_t exp_q[$];
   iacu_exp_t seen_e;
   logic clk, rst_n, req, valid, use_imm, user, done, wr, trap, cur_v;
   logic [OP_W-1:0] op;
   logic [WORD_W-1:0] a, b, sa, sb, res, rng, r1;
   logic [IMM_W-1:0] imm;
   logic [VEC_W-1:0] vec, tvec;
   logic [FLAG_W-1:0] fl, ref_fl;
   logic [WORD_W-1:0] pa [4] = '{32'h00000001, 32'h80000000, 32'h7FFFFFFF, 32'hFFFFFFFF};
   logic [WORD_W-1:0] pb [4] = '{32'h00000001, 32'h00000001, 32'h7FFFFFFF, 32'h00000001};
   int fail_count, n_checks;

   iacu_decode_model decode (.i_clk(clk), .i_req(req), .i_a(a), .i_b(b), .o_valid(valid), .o_src_a(sa),
      .o_src_b(sb));
   iacu_unit uut (.i_clk(clk), .i_rst_n(rst_n), .i_valid(valid), .i_op(op), .i_src_a(sa), .i_src_b(sb),
      .i_imm8(imm), .i_use_imm(use_imm), .i_vector(vec), .i_user_mode(user), .o_done(done), .o_write(wr),
      .o_result(res), .o_trap(trap), .o_trap_vector(tvec), .o_flags(fl));

   // ****************************************************************
   // Reference behaviour
   // ****************************************************************
   function automatic iacu_exp_t model(input logic [6:0] o, input logic [31:0] x0, input logic [31:0] y0,
      input logic u, input logic [7:0] v);
      iacu_exp_t e;
      logic [32:0] s;
      logic [31:0] x, y;
      logic eq, lt, t, ill, ov;
      e = '{wr: 1'b0, res: 32'h0, tr: 1'b1, vec: VEC_ILLEGAL, fl: ref_fl};
      eq = x0 == y0;
      lt = o[3] ? x0 < y0 : $signed(x0) < $signed(y0);
      if (o[6:5] == CLS_ARITH && o[1:0] != 2'h3) begin
         x = o[3] ? y0 : x0;
         y = o[3] ? x0 : y0;
         if (o[4]) s = {1'b0, x} + {1'b0, ~y} + (o[2] ? ref_fl[FL_C] : 1'b1);
         else s = {1'b0, x} + {1'b0, y} + (o[2] & ref_fl[FL_C]);
         ov = (x[31] ^ s[31]) & (o[4] ? (x[31] ^ y[31]) : ~(x[31] ^ y[31]));
         e.wr = 1'b1;
         e.res = s[31:0];
         e.tr = (o[1:0] == CHK_SIGNED && ov) || (o[1:0] == CHK_UNSIGNED && (s[32] ^ o[4]));
         e.vec = VEC_OUT_OF_RANGE;
         e.fl = {ov, s[31], s[31:0] == 32'h0, s[32]};
      end else if (o[6:5] == CLS_CMP) begin
         ill = o[2:0] == 3'h7 || (o[2:0] < 3'h2 && o[3]) || (o[2:0] == REL_BYTE && (o[4] | o[3]));
         t = (o[2:0] == REL_EQ && eq) || (o[2:0] == REL_NE && !eq) || (o[2:0] == REL_LT && lt)
            || (o[2:0] == REL_LE && (lt || eq)) || (o[2:0] == REL_GT && !lt && !eq) || (o[2:0] == REL_GE && !lt)
            || (o[2:0] == REL_BYTE && (x0[7:0] == y0[7:0] || x0[15:8] == y0[15:8]
            || x0[23:16] == y0[23:16] || x0[31:24] == y0[31:24]));
         if (!ill) begin
            e.wr = !o[4];
            e.res = t ? BOOL_TRUE : BOOL_FALSE;
            e.tr = o[4] & !t;
            e.vec = (u && v <= VEC_USER_LIMIT) ? VEC_PROTECT : v;
         end
      end else if (o[6:5] == CLS_MULDIV && o[4:0] < MD_COUNT) begin
         e.vec = VEC_MD_BASE + {3'h0, o[4:0]};
      end else if (o[6:5] == CLS_EMUL && o[4:0] < EMUL_COUNT) begin
         e.vec = VEC_EMUL_BASE + {3'h0, o[4:0]};
      end
      return e;
   endfunction : model

   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] r;
      r = s ^ (s << 13);
      r = r ^ (r >> 17);
      return r ^ (r << 5);
   endfunction : xorshift

   // ****************************************************************
   // Tasks
   // ****************************************************************
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] want);
      n_checks++;
      if (seen !== want) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", name, want, seen);
      end
   endtask : check

   task automatic issue(input logic [6:0] o, input logic [31:0] x, input logic [31:0] y, input logic [7:0] k,
      input logic ui, input logic u, input logic [7:0] v);
      @(negedge clk);
      exp_q.push_back(model(o, x, ui ? {24'h0, k} : y, u, v));
      ref_fl = exp_q[$].fl;
      req = 1'b1;
      op = o;
      a = x;
      b = y;
      imm = k;
      use_imm = ui;
      user = u;
      vec = v;
   endtask : issue

   task automatic idle(input int n);
      @(negedge clk);
      req = 1'b0;
      repeat (n) @(negedge clk);
   endtask : idle

   task automatic do_reset;
      if (rst_n) idle(2);
      rst_n = 1'b0;
      repeat (6) @(negedge clk);
      check("reset_ctl", {done, wr, trap, tvec, fl}, 32'h0);
      check("reset_res", res, 32'h0);
      ref_fl = FLAGS_RESET;
      rst_n = 1'b1;
   endtask : do_reset

   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : final_report

   // ****************************************************************
   // Clock, monitor, watchdog
   // ****************************************************************
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   always @(posedge clk) begin
      cur_v = valid & rst_n;
      #1;
      check("done", done, cur_v);
      if (done === 1'b1 && exp_q.size() > 0) begin
         seen_e = exp_q.pop_front();
         check("write", wr, seen_e.wr);
         if (seen_e.wr) check("result", res, seen_e.res);
         check("trap", trap, seen_e.tr);
         if (seen_e.tr) check("vector", tvec, seen_e.vec);
         check("flags", fl, seen_e.fl);
      end
   end

   initial begin
      #1000000;
      fail_count++;
      final_report();
   end

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      rst_n = 1'b0;
      req = 1'b0;
      op = 7'h00;
      a = 32'h0;
      b = 32'h0;
      imm = 8'h00;
      use_imm = 1'b0;
      user = 1'b0;
      vec = 8'h00;
      rng = 32'h00000004;
      fail_count = 0;
      n_checks = 0;
      do_reset();
      issue(7'h00, 32'h00000005, 32'h00000003, 8'h00, 1'b0, 1'b0, 8'h00);
      issue(7'h00, 32'h00000001, 32'hFFFFFFFF, 8'hFF, 1'b1, 1'b0, 8'h00);
      for (int o = 0; o < 128; o++) begin
         for (int k = 0; k < 4; k++) begin
            issue(o[6:0], pa[k], pb[k], 8'hFF, 1'b0, k[0], k[1] ? 8'h3F : 8'h40);
         end
      end
      for (int i = 0; i < 3000; i++) begin
         rng = xorshift(rng);
         r1 = xorshift(rng);
         if (rng[15:12] == 4'h0) idle(1);
         issue(rng[6:0], r1, rng[8] ? r1 ^ (rng & 32'hFF00FF00) : rng, rng[23:16], rng[9], rng[10], r1[7:0]);
      end
      do_reset();
      issue(7'h04, 32'h00000005, 32'h00000003, 8'h00, 1'b0, 1'b0, 8'h00);
      idle(3);
      check("drain", exp_q.size(), 32'h0);
      final_report();
   end
endmodule : iacu_unit_tb
`default_nettype wire
